// ---- awd_consts.vh ----
`ifndef AWD_CONSTS_VH
`define AWD_CONSTS_VH

// Register addresses on the special-function register port.
`define AWD_ADDR_TRACK      8'hba
`define AWD_ADDR_CTRL       8'he0
`define AWD_ADDR_UPPER_HI   8'hc4
`define AWD_ADDR_UPPER_LO   8'hc3
`define AWD_ADDR_LOWER_HI   8'hc6
`define AWD_ADDR_LOWER_LO   8'hc5
`define AWD_ADDR_RESULT_HI  8'hbe
`define AWD_ADDR_RESULT_LO  8'hbd

// Reset values.
`define AWD_RST_TRACK       8'hff
`define AWD_RST_CTRL        8'h00
`define AWD_RST_UPPER       16'hffff
`define AWD_RST_LOWER       16'h0000
`define AWD_RST_UPPER_HI    8'hff
`define AWD_RST_UPPER_LO    8'hff
`define AWD_RST_LOWER_HI    8'h00
`define AWD_RST_LOWER_LO    8'h00
`define AWD_RST_RESULT      16'h0000

// Control register field positions.
`define AWD_CTRL_ENABLE     7
`define AWD_CTRL_BURST      6
`define AWD_CTRL_DONE       5
`define AWD_CTRL_BUSY       4
`define AWD_CTRL_WINDOW     3
`define AWD_CTRL_LJUST      2
`define AWD_CTRL_MODE_HI    1
`define AWD_CTRL_MODE_LO    0

// Start mode that lets a write of the busy bit begin a conversion.
`define AWD_MODE_SOFT       2'h0

// Converter data width and the padding used for left justification.
`define AWD_RAW_W           12
`define AWD_PAD             4'h0

`endif

// ---- awd_compare.v ----
module awd_compare (
  input  wire [15:0] result_word,
  input  wire [15:0] upper_limit,
  input  wire [15:0] lower_limit,
  output wire        inside_mode,
  output wire        match
);

  wire above_upper;
  wire below_lower;

  // Only the relative order of the two limits picks the condition. [RULE4]
  assign inside_mode = (lower_limit > upper_limit); // [RULE4]

  // Both comparisons are strict and unsigned. [RULE5]
  assign above_upper = (result_word > upper_limit); // [RULE5]
  assign below_lower = (result_word < lower_limit);

  // Inside needs both strict bounds; outside needs either one. Equal limits fall to
  // the outside form, so every result but the limit value itself matches.
  assign match = inside_mode ? (above_upper & below_lower)  // [RULE6]
                             : (above_upper | below_lower); // [RULE7] [RULE9]

endmodule

// ---- awd_top.v ----
// Contract
// RULE1: Compare each new result against programmed limits.
// RULE2: Window flag readable whether or not interrupts used.
// RULE3: Two limits held in writable high/low byte pairs.
// RULE4: Limit order alone selects inside or outside.
// RULE5: Results are unsigned twelve-bit integers.
// RULE6: Lower above upper: match strictly between limits.
// RULE7: Outside form: match strictly beyond either bound.
// RULE8: Compare the sixteen-bit word as justified.
// RULE9: Upper above lower selects the outside form.
// RULE10: Flag stays set until software writes zero.
`include "awd_consts.vh"

module awd_top (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire [7:0]            sfr_addr,
  input  wire [7:0]            sfr_wdata,
  input  wire                  sfr_wr,
  input  wire                  sfr_rd,
  input  wire                  result_valid,
  input  wire [`AWD_RAW_W-1:0] result_raw,
  input  wire                  conv_busy,
  output reg  [7:0]            sfr_rdata,
  output reg                   conv_start,
  output reg                   window_event,
  output wire                  converter_enable,
  output wire                  burst_mode_enable,
  output wire                  left_justify,
  output wire [1:0]            start_mode,
  output wire [7:0]            tracking_timing,
  output wire                  window_match_flag,
  output wire                  conversion_done
);

  reg  [7:0]  tracking_and_power_up_timing;
  reg         ctrl_enable;
  reg         ctrl_burst;
  reg         ctrl_done;
  reg         ctrl_window;
  reg         ctrl_ljust;
  reg  [1:0]  ctrl_mode;
  reg  [7:0]  upper_compare_high_byte;
  reg  [7:0]  upper_compare_low_byte;
  reg  [7:0]  lower_compare_high_byte;
  reg  [7:0]  lower_compare_low_byte;
  reg  [15:0] result_word;

  wire [15:0] incoming_word;
  wire [15:0] upper_limit;
  wire [15:0] lower_limit;
  wire        inside_mode;
  wire        window_hit;
  wire        match_now;
  wire        wr_track;
  wire        wr_ctrl;
  wire        wr_upper_hi;
  wire        wr_upper_lo;
  wire        wr_lower_hi;
  wire        wr_lower_lo;
  wire        clear_window;
  wire        clear_done;
  wire        next_window;
  wire        next_done;
  wire        next_start;
  wire [7:0]  ctrl_view;
  reg  [7:0]  next_rdata;

  // Place the twelve-bit code in the sixteen-bit word the way software sees it.
  function [15:0] awd_justify;
    input                  ljust;
    input [`AWD_RAW_W-1:0] raw;
    begin
      if (ljust) begin
        awd_justify = {raw, `AWD_PAD};
      end else begin
        awd_justify = {`AWD_PAD, raw};
      end
    end
  endfunction

  // Address match, shared by every write decode.
  function awd_sel;
    input [7:0] addr;
    input [7:0] target;
    begin
      awd_sel = (addr == target);
    end
  endfunction

  // The comparison looks at the word as it will be stored, justification included. [RULE8]
  assign incoming_word = awd_justify(ctrl_ljust, result_raw); // [RULE8]
  assign upper_limit   = {upper_compare_high_byte, upper_compare_low_byte}; // [RULE3]
  assign lower_limit   = {lower_compare_high_byte, lower_compare_low_byte}; // [RULE3]

  awd_compare awd_compare_inst (
    .result_word (incoming_word),
    .upper_limit (upper_limit),
    .lower_limit (lower_limit),
    .inside_mode (inside_mode),
    .match       (match_now)
  );

  // Every delivered result is judged, so no conversion escapes the check. [RULE1]
  assign window_hit = result_valid & match_now; // [RULE1]

  assign wr_track    = sfr_wr & awd_sel(sfr_addr, `AWD_ADDR_TRACK);
  assign wr_ctrl     = sfr_wr & awd_sel(sfr_addr, `AWD_ADDR_CTRL);
  assign wr_upper_hi = sfr_wr & awd_sel(sfr_addr, `AWD_ADDR_UPPER_HI);
  assign wr_upper_lo = sfr_wr & awd_sel(sfr_addr, `AWD_ADDR_UPPER_LO);
  assign wr_lower_hi = sfr_wr & awd_sel(sfr_addr, `AWD_ADDR_LOWER_HI);
  assign wr_lower_lo = sfr_wr & awd_sel(sfr_addr, `AWD_ADDR_LOWER_LO);

  // Writing one to a sticky flag is ignored; only a zero clears it.
  assign clear_window = wr_ctrl & ~sfr_wdata[`AWD_CTRL_WINDOW];
  assign clear_done   = wr_ctrl & ~sfr_wdata[`AWD_CTRL_DONE];

  // A match in the same cycle as a clear keeps the flag set, so no event is lost.
  assign next_window = window_hit | (ctrl_window & ~clear_window); // [RULE10]
  assign next_done   = result_valid | (ctrl_done & ~clear_done);

  // A write of one to the busy bit starts a conversion only in software start mode.
  assign next_start = wr_ctrl & sfr_wdata[`AWD_CTRL_BUSY] & ctrl_enable &
                      (ctrl_mode == `AWD_MODE_SOFT);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tracking_and_power_up_timing <= `AWD_RST_TRACK;
      ctrl_enable                  <= 1'b0;
      ctrl_burst                   <= 1'b0;
      ctrl_done                    <= 1'b0;
      ctrl_window                  <= 1'b0;
      ctrl_ljust                   <= 1'b0;
      ctrl_mode                    <= 2'h0;
      upper_compare_high_byte      <= `AWD_RST_UPPER_HI;
      upper_compare_low_byte       <= `AWD_RST_UPPER_LO;
      lower_compare_high_byte      <= `AWD_RST_LOWER_HI;
      lower_compare_low_byte       <= `AWD_RST_LOWER_LO;
      result_word                  <= `AWD_RST_RESULT;
      conv_start                   <= 1'b0;
      window_event                 <= 1'b0;
    end else begin
      if (wr_track) begin
        tracking_and_power_up_timing <= sfr_wdata;
      end
      if (wr_ctrl) begin
        ctrl_enable <= sfr_wdata[`AWD_CTRL_ENABLE];
        ctrl_burst  <= sfr_wdata[`AWD_CTRL_BURST];
        ctrl_ljust  <= sfr_wdata[`AWD_CTRL_LJUST];
        ctrl_mode   <= sfr_wdata[`AWD_CTRL_MODE_HI:`AWD_CTRL_MODE_LO];
      end
      if (wr_upper_hi) begin
        upper_compare_high_byte <= sfr_wdata; // [RULE3]
      end
      if (wr_upper_lo) begin
        upper_compare_low_byte <= sfr_wdata; // [RULE3]
      end
      if (wr_lower_hi) begin
        lower_compare_high_byte <= sfr_wdata; // [RULE3]
      end
      if (wr_lower_lo) begin
        lower_compare_low_byte <= sfr_wdata; // [RULE3]
      end
      if (result_valid) begin
        result_word <= incoming_word;
      end
      ctrl_window  <= next_window; // [RULE10]
      ctrl_done    <= next_done;
      conv_start   <= next_start;
      window_event <= window_hit; // [RULE1]
    end
  end

  assign ctrl_view = {ctrl_enable, ctrl_burst, ctrl_done, conv_busy,
                      ctrl_window, ctrl_ljust, ctrl_mode};

  // Read data is registered, so it appears one cycle after the read strobe.
  // Unmapped addresses read as zero.
  always @* begin
    next_rdata = 8'h00;
    case (sfr_addr)
      `AWD_ADDR_TRACK: begin
        next_rdata = tracking_and_power_up_timing;
      end
      `AWD_ADDR_CTRL: begin
        next_rdata = ctrl_view; // [RULE2]
      end
      `AWD_ADDR_UPPER_HI: begin
        next_rdata = upper_compare_high_byte;
      end
      `AWD_ADDR_UPPER_LO: begin
        next_rdata = upper_compare_low_byte;
      end
      `AWD_ADDR_LOWER_HI: begin
        next_rdata = lower_compare_high_byte;
      end
      `AWD_ADDR_LOWER_LO: begin
        next_rdata = lower_compare_low_byte;
      end
      `AWD_ADDR_RESULT_HI: begin
        next_rdata = result_word[15:8];
      end
      `AWD_ADDR_RESULT_LO: begin
        next_rdata = result_word[7:0];
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  assign converter_enable  = ctrl_enable;
  assign burst_mode_enable = ctrl_burst;
  assign left_justify      = ctrl_ljust;
  assign start_mode        = ctrl_mode;
  assign tracking_timing   = tracking_and_power_up_timing;
  assign window_match_flag = ctrl_window; // [RULE2]
  assign conversion_done   = ctrl_done;

endmodule

// ---- awd_checker_sva.sv ----
module awd_checker (
  input wire       clk,
  input wire       rstn,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire       result_valid,
  input wire [7:0] sfr_rdata,
  input wire       window_event,
  input wire       window_match_flag,
  input wire       conversion_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire ctl_wr = sfr_wr && sfr_addr == 8'he0;
  event_has_flag_a: assert property (window_event |-> window_match_flag)
    else $error("event without flag");
  event_has_cause_a: assert property (window_event |-> $past(result_valid))
    else $error("event without result");
  flag_rise_event_a: assert property ($rose(window_match_flag) |-> window_event)
    else $error("flag rose silently");
  result_sets_done_a: assert property (result_valid |=> conversion_done)
    else $error("done not set");
  flag_holds_a: assert property (window_match_flag && !ctl_wr |=> window_match_flag)
    else $error("flag dropped");
  flag_clears_a: assert property (ctl_wr && !sfr_wdata[3] && !result_valid |=>
    !window_match_flag) else $error("flag not cleared");
  flag_no_set_a: assert property (!window_match_flag && !result_valid |=>
    !window_match_flag) else $error("flag set by write");
  flag_readable_a: assert property (sfr_rd && sfr_addr == 8'he0 |=>
    sfr_rdata[3] == $past(window_match_flag)) else $error("flag read wrong");
  cover property (window_event);
  cover property (ctl_wr && window_match_flag);
  cover property (sfr_rd && sfr_addr == 8'he0 && window_match_flag);
endmodule

bind awd_top awd_checker awd_checker_inst (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .result_valid(result_valid),
  .sfr_rdata(sfr_rdata), .window_event(window_event), .window_match_flag(window_match_flag),
  .conversion_done(conversion_done));

// ---- adc_window_detector_test.sv ----
module adc_window_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, sfr_wr, sfr_rd, result_valid, conv_busy;
  logic [7:0]  sfr_addr, sfr_wdata, cv;
  logic [11:0] result_raw;
  wire  [7:0]  sfr_rdata, tracking_timing;
  wire  [1:0]  start_mode;
  wire         conv_start, window_event, converter_enable, burst_mode_enable, left_justify;
  wire         window_match_flag, conversion_done;
  int          failures = 0;
  int          n_compared = 0;
  awd_top awd_top_inst (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .result_valid(result_valid), .result_raw(result_raw),
    .conv_busy(conv_busy), .sfr_rdata(sfr_rdata), .conv_start(conv_start),
    .window_event(window_event), .converter_enable(converter_enable),
    .burst_mode_enable(burst_mode_enable), .left_justify(left_justify),
    .start_mode(start_mode), .tracking_timing(tracking_timing),
    .window_match_flag(window_match_flag), .conversion_done(conversion_done));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 {sfr_rd, sfr_addr} = {1'b1, a};
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic lim(input logic [15:0] up, input logic [15:0] lo);
    wr(8'hc4, up[15:8]);
    wr(8'hc3, up[7:0]);
    wr(8'hc6, lo[15:8]);
    wr(8'hc5, lo[7:0]);
  endtask
  task automatic pulse(input logic [11:0] raw);
    @(posedge clk);
    #1 {result_valid, result_raw} = {1'b1, raw};
    @(posedge clk);
    #1 result_valid = 1'b0;
  endtask
  // The flag is cleared after every result so the next check starts clean.
  task automatic res(input logic [11:0] raw, input logic m);
    pulse(raw);
    chk({window_event, window_match_flag}, {m, m});
    wr(8'he0, cv);
  endtask
  task automatic t_reset();
    rdc(8'hba, 8'hff);
    rdc(8'hc4, 8'hff);
    rdc(8'hc5, 8'h00);
    rdc(8'he0, 8'h10);
    rdc(8'h55, 8'h00);
    wr(8'hba, 8'h5a);
    chk(tracking_timing, 8'h5a);
    conv_busy = 1'b0;
    $display("t_reset done");
  endtask
  task automatic t_inside();
    lim(16'h0100, 16'h0200);
    rdc(8'hc6, 8'h02);
    res(12'h100, 1'b0);
    res(12'h101, 1'b1);
    res(12'h1ff, 1'b1);
    res(12'h200, 1'b0);
    $display("t_inside done");
  endtask
  task automatic t_outside();
    lim(16'h0200, 16'h0100);
    res(12'h0ff, 1'b1);
    res(12'h100, 1'b0);
    res(12'h200, 1'b0);
    res(12'h201, 1'b1);
    res(12'hfff, 1'b1);
    lim(16'h0300, 16'h0300);
    res(12'h300, 1'b0);
    res(12'h2ff, 1'b1);
    $display("t_outside done");
  endtask
  task automatic t_ljust();
    cv = 8'h04;
    wr(8'he0, cv);
    lim(16'h1000, 16'h2000);
    res(12'h100, 1'b0);
    res(12'h101, 1'b1);
    rdc(8'hbe, 8'h10);
    rdc(8'hbd, 8'h10);
    $display("t_ljust done");
  endtask
  task automatic t_sticky();
    pulse(12'h101);
    pulse(12'h001);
    chk(window_match_flag, 1'b1);
    rdc(8'he0, 8'h2c);
    wr(8'he0, 8'h0c);
    chk(window_match_flag, 1'b1);
    wr(8'he0, cv);
    chk(window_match_flag, 1'b0);
    @(posedge clk);
    #1 {sfr_wr, sfr_addr, sfr_wdata, result_valid, result_raw} = {1'b1, 8'he0, cv, 1'b1, 12'h101};
    @(posedge clk);
    #1 {sfr_wr, result_valid} = 2'h0;
    chk(window_match_flag, 1'b1);
    wr(8'he0, cv);
    $display("t_sticky done");
  endtask
  task automatic t_start();
    wr(8'he0, 8'h81);
    chk({converter_enable, start_mode}, 3'h5);
    wr(8'he0, 8'h91);
    chk(conv_start, 1'b0);
    wr(8'he0, 8'h80);
    wr(8'he0, 8'h90);
    chk(conv_start, 1'b1);
    @(posedge clk);
    #1 chk(conv_start, 1'b0);
    wr(8'he0, 8'h40);
    chk({burst_mode_enable, converter_enable, left_justify}, 3'h4);
    wr(8'he0, 8'h50);
    chk(conv_start, 1'b0);
    $display("t_start done");
  endtask
  task automatic t_midreset();
    wr(8'he0, 8'h04);
    pulse(12'h101);
    chk(window_match_flag, 1'b1);
    wr(8'hba, 8'h33);
    wr(8'hc4, 8'h12);
    @(posedge clk);
    #1 rstn = 1'b0;
    @(posedge clk);
    #1 rstn = 1'b1;
    chk({tracking_timing, window_match_flag, conversion_done, conv_start}, 11'h7f8);
    rdc(8'hc4, 8'hff);
    rdc(8'he0, 8'h00);
    $display("t_midreset done");
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rstn, sfr_wr, sfr_rd, result_valid, conv_busy} = 5'h01;
    {sfr_addr, sfr_wdata, cv, result_raw} = 36'h0;
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    t_reset();
    t_inside();
    t_outside();
    t_ljust();
    t_sticky();
    t_start();
    t_midreset();
    give_verdict();
  end
  // Tests take well under 1000 cycles, so this span only fires on a hang.
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
endmodule
